/* logic/cic_pkg.sv */
// Constants, types and register map of the core interrupt controller.
// Assumes one clock, clk_sys, and the plain register port of the core.
//
// Summary of operation
// - Flags latch regardless of any mask bit
// - Control bit 7 is global enable
// - Enabled flag with mask vectors immediately
// - Every reset clears the global enable
// - Return op pops address, sets global enable
// - Service clears enable, pushes, jumps 0004h
// - Peripheral flags gated by peripheral gate
// - Pin and port latency three-four cycles awake, five from sleep
// - Pin edge polarity from option bit 6
// - Pin edge sets bit 1, mask bit 4
// - Masked pin edge wakes core from sleep
// - Timer rollover FFh to 00h sets bit 2
// - Timer overflow mask is bit 5
// - Upper port change sets bit 0, mask 3
// - Up to nine flagged, individually enabled sources
// - Wake with enable vectors, else next instruction
// - Enabled request wakes regardless of global enable
// - Pending request makes sleep a no-operation
package cic_pkg;

  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam logic [2:0] ADDR_IRQ_CONTROL   = 3'h0;
  localparam logic [2:0] ADDR_OPTION_CONFIG = 3'h1;
  localparam logic [2:0] ADDR_PERIPH_FLAG   = 3'h2;
  localparam logic [2:0] ADDR_PERIPH_MASK   = 3'h3;
  localparam logic [2:0] ADDR_CORE_STATUS   = 3'h4;

  // --------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------
  localparam int BIT_PORT_FLAG   = 0;
  localparam int BIT_EXT_FLAG    = 1;
  localparam int BIT_TIMER_FLAG  = 2;
  localparam int BIT_PORT_MASK   = 3;
  localparam int BIT_EXT_MASK    = 4;
  localparam int BIT_TIMER_MASK  = 5;
  localparam int BIT_PERIPH_GATE = 6;
  localparam int BIT_GLOBAL_EN   = 7;
  localparam int BIT_EDGE_SELECT = 6;

  // --------------------------------------------------------------
  // Reset values and constants
  // --------------------------------------------------------------
  localparam logic [7:0]  RST_IRQ_CONTROL   = 8'h00;
  localparam logic [7:0]  RST_OPTION_CONFIG = 8'hff;
  localparam logic [7:0]  RST_PERIPH        = 8'h00;
  localparam logic [12:0] IRQ_VECTOR        = 13'h0004;
  localparam logic [7:0]  TIMER_TOP         = 8'hff;
  localparam int          PERIPH_SOURCES    = 6;
  // Sync stages plus one qualify cycle give three or four cycles
  localparam int          SYNC_STAGES       = 2;

  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    CIC_RUN,
    CIC_SLEEP,
    CIC_VECTOR
  } cic_state_t;

  typedef struct packed {
    logic        valid;
    logic [12:0] target_pc;
    logic        push;
  } cic_jump_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } cic_bus_t;

endpackage

/* logic/cic_sync.sv */
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes asynchronous inputs and the system clock.
`timescale 1ns/1ps
module cic_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // ------------------------------------------------------------
  // Two stages, only the second is read
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

/* logic/cic_top.sv */
// Interrupt controller for the small core: flags, masks, sleep, vector.
// Assumes the core sequencer runs on clk_sys, one instruction per cycle
// as seen here, that peripherals pulse their events and that the timer presents its count.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module cic_top #(
  parameter int NPERIPH = cic_pkg::PERIPH_SOURCES
) (
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  input  wire logic [2:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  input  wire logic               ext_irq_pin,
  input  wire logic [3:0]         upper_port,
  input  wire logic [7:0]         eight_bit_timer,
  input  wire logic [NPERIPH-1:0] periph_event,
  input  wire logic               sleep_op,
  input  wire logic               return_from_irq_op,
  input  wire logic [12:0]        pc_next,
  input  wire logic               vector_ack,
  output logic                    irq_req,
  output logic                    core_asleep,
  output logic                    sleep_as_nop,
  output logic                    sleep_taken,
  output logic                    wake_pulse,
  output logic                    jump_valid,
  output logic [12:0]             jump_pc,
  output logic                    stack_push,
  output logic                    stack_pop
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  cic_pkg::cic_state_t    state_q;
  cic_pkg::cic_jump_t     jump_d;
  cic_pkg::cic_bus_t      bus;
  logic [7:0]             irq_control_q;
  logic [7:0]             option_config_q;
  logic [NPERIPH-1:0]     periph_flag_q;
  logic [NPERIPH-1:0]     periph_mask_q;
  logic [4:0]             pins_s;
  logic                   ext_s_q;
  logic [3:0]             port_s_q;
  logic [7:0]             timer_q;
  logic                   ext_edge;
  logic                   port_change;
  logic                   timer_wrap;
  logic                   pending;
  logic [2:0]             core_flag_v;
  logic [2:0]             core_mask_v;
  logic [2:0]             core_hit_v;
  logic                   take_irq;
  logic                   global_irq_enable;
  logic                   peripheral_irq_gate;
  logic                   ext_edge_select;

  assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
  assign global_irq_enable   = irq_control_q[cic_pkg::BIT_GLOBAL_EN];
  assign peripheral_irq_gate = irq_control_q[cic_pkg::BIT_PERIPH_GATE];
  assign ext_edge_select     = option_config_q[cic_pkg::BIT_EDGE_SELECT];

  // ------------------------------------------------------------
  // Pin synchronisation and event detection
  // ------------------------------------------------------------
  cic_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .async_in({upper_port, ext_irq_pin}),
    .sync_out(pins_s)
  );

  // Previous-value registers; reset values mimic a quiet pin
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ext_s_q  <= 1'b0;
      port_s_q <= 4'h0;
      timer_q  <= 8'h00;
    end else begin
      ext_s_q  <= pins_s[0];
      port_s_q <= pins_s[4:1];
      timer_q  <= eight_bit_timer;
    end
  end

  // Rising when select is one, falling when zero
  assign ext_edge = ext_edge_select ? (pins_s[0] & ~ext_s_q)
                                    : (~pins_s[0] & ext_s_q);
  assign port_change = |(pins_s[4:1] ^ port_s_q);
  assign timer_wrap  = (timer_q == cic_pkg::TIMER_TOP) &&
                       (eight_bit_timer == 8'h00);

  // ------------------------------------------------------------
  // Request combining
  // ------------------------------------------------------------
  // Core sources in bit order: port change, pin, timer overflow
  // Flags and masks share one register, so no stale hit on a write
  assign core_flag_v = {irq_control_q[cic_pkg::BIT_TIMER_FLAG],
                        irq_control_q[cic_pkg::BIT_EXT_FLAG],
                        irq_control_q[cic_pkg::BIT_PORT_FLAG]};
  assign core_mask_v = {irq_control_q[cic_pkg::BIT_TIMER_MASK],
                        irq_control_q[cic_pkg::BIT_EXT_MASK],
                        irq_control_q[cic_pkg::BIT_PORT_MASK]};

  generate
    for (genvar c = 0; c < 3; c++) begin : g_core
      // Mask gates the request only, never the flag
      assign core_hit_v[c] = core_flag_v[c] & core_mask_v[c];
    end
  endgenerate

  // Core flags with own masks, peripherals behind the gate
  assign pending = (|core_hit_v) |
                   (peripheral_irq_gate &
                    |(periph_flag_q & periph_mask_q));

  // Only the CIC_RUN state is further required once enable and mask agree
  assign take_irq = pending && global_irq_enable &&
                    (state_q == cic_pkg::CIC_RUN);

  // ------------------------------------------------------------
  // Interrupt control register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_control_q <= cic_pkg::RST_IRQ_CONTROL;
    end else begin
      if (bus.wr && bus.addr == cic_pkg::ADDR_IRQ_CONTROL) begin
        irq_control_q <= bus.wdata;
      end
      // Entering the routine wins over a same-cycle write
      if (take_irq) begin
        irq_control_q[cic_pkg::BIT_GLOBAL_EN] <= 1'b0;
      end else if (return_from_irq_op) begin
        irq_control_q[cic_pkg::BIT_GLOBAL_EN] <= 1'b1;
      end
      // Events set flags regardless of masks; set beats clear
      if (port_change) begin
        irq_control_q[cic_pkg::BIT_PORT_FLAG] <= 1'b1;
      end
      if (ext_edge) begin
        irq_control_q[cic_pkg::BIT_EXT_FLAG] <= 1'b1;
      end
      if (timer_wrap) begin
        irq_control_q[cic_pkg::BIT_TIMER_FLAG] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Option register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      option_config_q <= cic_pkg::RST_OPTION_CONFIG;
    end else if (bus.wr && bus.addr == cic_pkg::ADDR_OPTION_CONFIG) begin
      option_config_q <= bus.wdata;
    end
  end

  // ------------------------------------------------------------
  // Peripheral flag and mask registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      periph_mask_q <= cic_pkg::RST_PERIPH[NPERIPH-1:0];
    end else if (bus.wr && bus.addr == cic_pkg::ADDR_PERIPH_MASK) begin
      periph_mask_q <= bus.wdata[NPERIPH-1:0];
    end
  end

  // Three core plus up to six peripheral sources make nine
  generate
    for (genvar i = 0; i < NPERIPH; i++) begin : g_pflag
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          periph_flag_q[i] <= 1'b0;
        end else if (periph_event[i]) begin
          periph_flag_q[i] <= 1'b1;
        end else if (bus.wr && bus.addr == cic_pkg::ADDR_PERIPH_FLAG) begin
          periph_flag_q[i] <= bus.wdata[i];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Sleep, wake and vector sequencing
  // ------------------------------------------------------------
  // Vector is issued one cycle after the request is seen;
  // with two sync stages the pin-to-jump path is three or four
  // cycles while the core runs; from sleep the wake cycle comes first, making five.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= cic_pkg::CIC_RUN;
    end else begin
      case (state_q)
        cic_pkg::CIC_RUN: begin
          if (take_irq) begin
            state_q <= cic_pkg::CIC_VECTOR;
          end else if (sleep_op && !pending) begin
            state_q <= cic_pkg::CIC_SLEEP;
          end
        end
        cic_pkg::CIC_SLEEP: begin
          // Wake does not look at the global enable
          if (pending) begin
            state_q <= cic_pkg::CIC_RUN;
          end
        end
        cic_pkg::CIC_VECTOR: begin
          if (vector_ack) begin
            state_q <= cic_pkg::CIC_RUN;
          end
        end
        default: state_q <= cic_pkg::CIC_RUN;
      endcase
    end
  end

  always_comb begin
    jump_d = '{valid: 1'b0, target_pc: pc_next, push: 1'b0};
    if (take_irq) begin
      jump_d = '{valid: 1'b1, target_pc: cic_pkg::IRQ_VECTOR,
                 push: 1'b1};
    end
  end

  // ------------------------------------------------------------
  // Registered outputs to the core
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_req      <= 1'b0;
      core_asleep  <= 1'b0;
      sleep_as_nop <= 1'b0;
      sleep_taken  <= 1'b0;
      wake_pulse   <= 1'b0;
      jump_valid   <= 1'b0;
      jump_pc      <= 13'h0000;
      stack_push   <= 1'b0;
      stack_pop    <= 1'b0;
    end else begin
      irq_req      <= pending & global_irq_enable;
      core_asleep  <= (state_q == cic_pkg::CIC_SLEEP) && !pending;
      // Pending request turns sleep into a no-operation
      sleep_as_nop <= sleep_op && pending &&
                      (state_q == cic_pkg::CIC_RUN);
      sleep_taken  <= sleep_op && !pending && !take_irq &&
                      (state_q == cic_pkg::CIC_RUN);
      wake_pulse   <= (state_q == cic_pkg::CIC_SLEEP) && pending;
      jump_valid   <= jump_d.valid;
      jump_pc      <= jump_d.target_pc;
      stack_push   <= jump_d.push;
      stack_pop    <= return_from_irq_op;
    end
  end

  // ------------------------------------------------------------
  // Register read port, data one cycle after strobe
  // ------------------------------------------------------------
  // Software must clear flags before the return op; not enforced.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        cic_pkg::ADDR_IRQ_CONTROL:   reg_rdata <= irq_control_q;
        cic_pkg::ADDR_OPTION_CONFIG: reg_rdata <= option_config_q;
        cic_pkg::ADDR_PERIPH_FLAG:
          reg_rdata <= 8'({periph_flag_q});
        cic_pkg::ADDR_PERIPH_MASK:
          reg_rdata <= 8'({periph_mask_q});
        cic_pkg::ADDR_CORE_STATUS:
          reg_rdata <= {5'h00, pending,
                        state_q == cic_pkg::CIC_VECTOR,
                        state_q == cic_pkg::CIC_SLEEP};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

/* sim/cic_top_props.sv */
// Checker on the interrupt controller top ports.
// Assumes one clock, clk_sys, and a synchronous active low reset.
`timescale 1ns/1ps
module cic_top_props #(
  parameter int NPERIPH = 6
) (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        return_from_irq_op,
  input wire logic        sleep_op,
  input wire logic        irq_req,
  input wire logic        core_asleep,
  input wire logic        sleep_as_nop,
  input wire logic        sleep_taken,
  input wire logic        wake_pulse,
  input wire logic        jump_valid,
  input wire logic [12:0] jump_pc,
  input wire logic        stack_push,
  input wire logic        stack_pop
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  vector_target_a: assert property (
    jump_valid |-> jump_pc == 13'h0004 && stack_push)
    else $error("vector without 0004 or push");
  push_alone_a: assert property (
    stack_push |-> jump_valid) else $error("push without vector");
  single_vector_a: assert property (
    jump_valid |=> !jump_valid [*2]) else $error("vector repeated");
  return_pop_a: assert property (
    return_from_irq_op |=> stack_pop) else $error("return without pop");
  pop_cause_a: assert property (
    stack_pop |-> $past(return_from_irq_op))
    else $error("pop without return");
  sleep_outcome_a: assert property (
    sleep_op |=> sleep_taken != sleep_as_nop)
    else $error("sleep outcome not unique");
  nop_awake_a: assert property (
    sleep_as_nop |-> !core_asleep) else $error("asleep after no-op");
  asleep_hold_a: assert property (
    sleep_taken |=> core_asleep || wake_pulse)
    else $error("sleep not entered");
  wake_exit_a: assert property (
    wake_pulse |-> !core_asleep &&
      ($past(core_asleep) || $past(sleep_taken)))
    else $error("wake without sleep");
  reset_clear_a: assert property (disable iff (1'b0)
    !reset_n |=> !irq_req && !jump_valid && !core_asleep)
    else $error("reset left request set");
endmodule

bind cic_top cic_top_props #(.NPERIPH(NPERIPH)) i_props (.*);

/* sim/cic_core_model.sv */
// Core sequencer model: fetch address and vector acknowledge.
// Assumes the controller pulses jump_valid once per vector.
`timescale 1ns/1ps
module cic_core_model (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        jump_valid,
  input  wire logic [1:0]  ack_delay,
  output logic             vector_ack,
  output logic [12:0]      pc_next
);
  logic [2:0] wait_q;
  // ------------------------------------------------------------
  // Fetch and acknowledge
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) pc_next <= 13'h0000;
    else pc_next <= pc_next + 13'h0001;
  end
  // Stall varies so both prompt and slow takes are seen
  always_ff @(posedge clk_sys) begin
    vector_ack <= 1'b0;
    if (!reset_n) wait_q <= 3'h0;
    else if (jump_valid) wait_q <= {1'b0, ack_delay} + 3'h1;
    else if (wait_q == 3'h1) begin
      wait_q <= 3'h0;
      vector_ack <= 1'b1;
    end else if (wait_q != 3'h0) wait_q <= wait_q - 3'h1;
  end
endmodule

/* sim/tb_cpu_interrupt_control.sv */
// Self-checking bench for the interrupt controller.
// Assumes cic_top, its checker bind and the core model.
`timescale 1ns/1ps
module tb_cpu_interrupt_control;
  logic clk_sys = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
  logic ext_irq_pin = 0, sleep_op = 0, return_from_irq_op = 0;
  logic [2:0]  reg_addr = 0;
  logic [7:0]  reg_wdata = 0, eight_bit_timer = 0, rd_q;
  logic [3:0]  upper_port = 0;
  logic [5:0]  periph_event = 0;
  logic [1:0]  ack_delay = 0;
  logic [7:0]  reg_rdata;
  logic [12:0] pc_next, jump_pc;
  logic vector_ack, irq_req, core_asleep, sleep_as_nop, sleep_taken;
  logic wake_pulse, jump_valid, stack_push, stack_pop, sel, from, to;
  logic [31:0] seed = 32'hbffe;
  int n_mismatch = 0, checks_done = 0, n, k;
  always #12.5 clk_sys = ~clk_sys;
  cic_top i_dut (.*);
  cic_core_model i_core (.clk_sys(clk_sys), .reset_n(reset_n),
    .jump_valid(jump_valid), .ack_delay(ack_delay),
    .vector_ack(vector_ack), .pc_next(pc_next));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic edge_hit(logic s, logic f, logic t);
    return s ? (!f && t) : (f && !t);
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(string nm, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [2:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rd_q = reg_rdata;
  endtask
  // Bounded wait: s=1 wake, s=0 vector; a miss ends the run
  task automatic wait_on(int s, int lim);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while ((s ? wake_pulse : jump_valid) !== 1'b1 && n < lim);
    check(s ? "wake" : "vector", 16'h1, 16'(s ? wake_pulse : jump_valid));
    if (n_mismatch > 0) end_of_test();
  endtask
  task automatic no_jump(int lim);
    logic seen;
    seen = 1'b0;
    repeat (lim) begin
      @(posedge clk_sys);
      #1;
      seen |= jump_valid;
    end
    check("no vector", 16'h0, 16'(seen));
  endtask
  task automatic roll(int tail);
    @(posedge clk_sys);
    eight_bit_timer <= 8'hff;
    @(posedge clk_sys);
    eight_bit_timer <= 8'h00;
    repeat (tail) @(posedge clk_sys);
  endtask
  task automatic do_sleep();
    @(posedge clk_sys);
    sleep_op <= 1'b1;
    @(posedge clk_sys);
    sleep_op <= 1'b0;
    #1;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(3'(i));
      check("reset value", (i == 1) ? 16'hff : 16'h0, 16'(rd_q));
    end
    // Pin edge table: rising/falling select, right and wrong edge
    for (int i = 0; i < 4; i++) begin
      sel = !i[1];
      to = !i[0];
      wr(cic_pkg::ADDR_OPTION_CONFIG, {1'b1, sel, 6'h3f});
      wr(cic_pkg::ADDR_IRQ_CONTROL, 8'h00);
      from = ext_irq_pin;
      ext_irq_pin <= to;
      repeat (6) @(posedge clk_sys);
      rd(cic_pkg::ADDR_IRQ_CONTROL);
      check("pin flag", 16'(edge_hit(sel, from, to)), 16'(rd_q[1]));
    end
    wr(cic_pkg::ADDR_OPTION_CONFIG, 8'hff);
    wr(cic_pkg::ADDR_IRQ_CONTROL, 8'h00);
    upper_port <= upper_port ^ (4'(xs()) | 4'h1);
    repeat (6) @(posedge clk_sys);
    rd(cic_pkg::ADDR_IRQ_CONTROL);
    check("port flag", 16'h1, 16'(rd_q[0]));
    roll(3);
    rd(cic_pkg::ADDR_IRQ_CONTROL);
    check("timer flag", 16'h1, 16'(rd_q[2]));
    check("request", 16'h0, 16'(irq_req));
    wr(cic_pkg::ADDR_IRQ_CONTROL, 8'h84);
    no_jump(6);
    wr(cic_pkg::ADDR_IRQ_CONTROL, 8'ha4);
    wait_on(0, 8);
    check("request", 16'h1, 16'(irq_req));
    check("vector pc", 16'h0004, 16'(jump_pc));
    rd(cic_pkg::ADDR_IRQ_CONTROL);
    check("enable cleared", 16'h0, 16'(rd_q[7]));
    wr(cic_pkg::ADDR_IRQ_CONTROL, 8'h20);
    @(posedge clk_sys);
    return_from_irq_op <= 1'b1;
    @(posedge clk_sys);
    return_from_irq_op <= 1'b0;
    #1;
    check("pop", 16'h1, 16'(stack_pop));
    rd(cic_pkg::ADDR_IRQ_CONTROL);
    check("enable set", 16'h1, 16'(rd_q[7]));
    no_jump(4);
    // Pin then port change latency with random acknowledge stall
    for (int j = 0; j < 2; j++) begin
      ack_delay <= 2'(xs());
      wr(cic_pkg::ADDR_IRQ_CONTROL, j ? 8'h88 : 8'h90);
      @(posedge clk_sys);
      if (j) upper_port <= ~upper_port;
      else ext_irq_pin <= ~ext_irq_pin;
      wait_on(0, 8);
      check("latency in range", 16'h1, 16'(n >= 3 && n <= 4));
    end
    k = xs() % 6;
    wr(cic_pkg::ADDR_PERIPH_MASK, 8'(1 << k));
    wr(cic_pkg::ADDR_IRQ_CONTROL, 8'h80);
    periph_event <= 6'(1 << k);
    @(posedge clk_sys);
    periph_event <= 6'h00;
    no_jump(6);
    rd(cic_pkg::ADDR_PERIPH_FLAG);
    check("periph flag", 16'(1 << k), 16'(rd_q));
    wr(cic_pkg::ADDR_IRQ_CONTROL, 8'hc0);
    wait_on(0, 8);
    wr(cic_pkg::ADDR_PERIPH_FLAG, 8'h00);
    wr(cic_pkg::ADDR_IRQ_CONTROL, 8'h20);
    roll(3);
    do_sleep();
    check("sleep no-op", 16'h1, 16'(sleep_as_nop && !sleep_taken));
    wr(cic_pkg::ADDR_IRQ_CONTROL, 8'h20);
    do_sleep();
    check("sleep entered", 16'h1, 16'(sleep_taken && !sleep_as_nop));
    @(posedge clk_sys);
    #1;
    check("asleep", 16'h1, 16'(core_asleep));
    roll(0);
    wait_on(1, 8);
    no_jump(6);
    ext_irq_pin <= 1'b0;
    wr(cic_pkg::ADDR_IRQ_CONTROL, 8'h90);
    do_sleep();
    ext_irq_pin <= 1'b1;
    wait_on(1, 8);
    wait_on(0, 4);
    check("wake vector", 16'h0004, 16'(jump_pc));
    end_of_test();
  end
endmodule
